// ### pmbl_phy_mode.sv
// phy mode control register, mode decode, symbol timing and link quality estimation
// ==========================================================================
// Functional notes
// - link quality reported as unsigned 0..255 with many distinct values
// - weakest correlation maps to 0x00, perfect to 0xff, linear between
// - after sync header, average correlation of several symbols per frame
// - link quality valid only at frame end; host reads it via frame buffer
// - bpsk at 300 or 600 kchip/s, 20 or 40 kb/s, rc-1.0 shaping
// - o-qpsk at 400 or 1000 kchip/s chosen by configuration
// - 400 kchip/s: sine plus rc-0.2, or rc-0.2 alone
// - 1000 kchip/s: half-sine or rc-0.8 shaping
// - standard o-qpsk gives 100 or 250 kb/s, 25 or 62.5 ksym/s
// - high rate modes shorten code by two or four, same bandwidth
// - 400 kchip/s: shortened codes give 200 and 400 kb/s
// - 1000 kchip/s: shortened codes give 500 and 1000 kb/s
// - bpsk symbol period 50 us at 20 kb/s, 25 us at 40 kb/s
// - o-qpsk symbol period 40 or 16 us, high rates inherit it
// - high rate modes usable in basic and extended modes, short ack option
// - mode logic independent of rf channel selection
// - modulation select: 0 bpsk, 1 o-qpsk, reset 0
// - chip rate select reset 1: 1000/600 kchip; 0: 400/300 kchip
// - two-bit payload rate select, 0 (reset) is standard rate
// - alternate shaping enable reset 0, 1 selects alternate shaping
`timescale 1ns/1ps
`include "pmbl_regs.svh"
module pmbl_phy_mode #(
  parameter int CORR_W = 8,
  parameter int LQI_SYMS = `PMBL_LQI_SYMS,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  // transceiver state
  input wire logic radio_idle_state_in,
  input wire logic short_ack_enable_in,
  // receive path events
  input wire logic sync_header_in,
  input wire logic [CORR_W-1:0] corr_data_in,
  input wire logic corr_valid_in,
  output logic corr_ready_out,
  input wire logic frame_end_in,
  // link quality to frame buffer
  output logic [7:0] lqi_out,
  output logic lqi_valid_out,
  output logic frame_done_interrupt_out,
  // active mode towards the modem datapath
  output logic modulation_select_out,
  output logic [9:0] chip_rate_kchip_out,
  output logic [9:0] payload_rate_kbps_out,
  output logic [1:0] spread_code_out,
  output logic [2:0] pulse_shape_out,
  output logic scrambler_enable_out,
  output logic [15:0] symbol_cycles_out,
  output logic symbol_tick_out,
  output logic [1:0] ack_symbols_out
);
  // ========================================================================
  // control register
  logic [7:0] ctrl_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= `PMBL_CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == `PMBL_CTRL_ADDR) begin
      ctrl_q <= {2'h0, reg_wdata_in[5:0]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else if (reg_read_in) begin
      rdata_q <= (reg_addr_in == `PMBL_CTRL_ADDR) ? ctrl_q : 8'h00;
    end
  end
  assign reg_rdata_out = rdata_q;

  // ========================================================================
  // active mode, latched only while radio idle
  logic [7:0] mode_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_q <= `PMBL_CTRL_RESET;
    end else if (radio_idle_state_in) begin
      mode_q <= ctrl_q;
    end
  end

  logic oqpsk;
  logic fast;
  logic alt;
  logic [1:0] rate_sel;
  assign oqpsk = mode_q[`PMBL_MOD_BIT];
  assign fast = mode_q[`PMBL_SUBMODE_BIT];
  assign alt = mode_q[`PMBL_ALT_BIT];
  assign rate_sel = mode_q[`PMBL_RATE_MSB:`PMBL_RATE_LSB];

  // ========================================================================
  // mode decode (channel plays no part)
  logic [9:0] chip_d;
  logic [9:0] rate_d;
  logic [1:0] spread_d;
  pmbl_pkg::pmbl_shape_e shape_d;
  logic [15:0] sym_cyc_d;

  always_comb begin
    spread_d = pmbl_pkg::PMBL_SPREAD_STD;
    if (!oqpsk) begin
      chip_d = fast ? 10'd600 : 10'd300;
      rate_d = fast ? 10'd40 : 10'd20;
      shape_d = pmbl_pkg::PMBL_PS_RC10;
      sym_cyc_d = fast ? 16'(`PMBL_SYM_CYC(`PMBL_SYM_US_BPSK40))
                       : 16'(`PMBL_SYM_CYC(`PMBL_SYM_US_BPSK20));
    end else begin
      chip_d = fast ? 10'd1000 : 10'd400;
      sym_cyc_d = fast ? 16'(`PMBL_SYM_CYC(`PMBL_SYM_US_OQ1000))
                       : 16'(`PMBL_SYM_CYC(`PMBL_SYM_US_OQ400));
      if (fast) begin
        shape_d = alt ? pmbl_pkg::PMBL_PS_RC08 : pmbl_pkg::PMBL_PS_SIN;
      end else begin
        shape_d = alt ? pmbl_pkg::PMBL_PS_RC02 : pmbl_pkg::PMBL_PS_SIN_RC02;
      end
      unique case (rate_sel)
        2'h0: begin
          rate_d = fast ? 10'd250 : 10'd100;
        end
        2'h1: begin
          rate_d = fast ? 10'd500 : 10'd200;
          spread_d = pmbl_pkg::PMBL_SPREAD_HALF;
        end
        default: begin
          rate_d = fast ? 10'd1000 : 10'd400;
          spread_d = pmbl_pkg::PMBL_SPREAD_QUARTER;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      modulation_select_out <= 1'b0;
      chip_rate_kchip_out <= 10'd0;
      payload_rate_kbps_out <= 10'd0;
      spread_code_out <= 2'h0;
      pulse_shape_out <= 3'h0;
      scrambler_enable_out <= 1'b0;
      symbol_cycles_out <= 16'h0000;
    end else begin
      modulation_select_out <= oqpsk;
      chip_rate_kchip_out <= chip_d;
      payload_rate_kbps_out <= rate_d;
      spread_code_out <= spread_d;
      pulse_shape_out <= shape_d;
      scrambler_enable_out <= oqpsk && mode_q[`PMBL_SCRAM_BIT] && rate_sel[1];
      symbol_cycles_out <= sym_cyc_d;
    end
  end

  // 0 means standard 12-symbol ack; 2 or 3 symbols in high rate modes with short ack enabled
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_symbols_out <= 2'h0;
    end else if (oqpsk && rate_sel != 2'h0 && short_ack_enable_in) begin
      ack_symbols_out <= fast ? 2'h3 : 2'h2;
    end else begin
      ack_symbols_out <= 2'h0;
    end
  end

  // ========================================================================
  // symbol period divider
  logic [15:0] sym_cnt_q;
  logic sym_wrap;

  // count restarts while idle, so the first tick comes a full period later
  assign sym_wrap = (sym_cnt_q >= sym_cyc_d - 16'h0001);

  always_ff @(posedge clk_in) begin
    if (reset_in || radio_idle_state_in) begin
      sym_cnt_q <= 16'h0000;
    end else if (sym_wrap) begin
      sym_cnt_q <= 16'h0000;
    end else begin
      sym_cnt_q <= sym_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || radio_idle_state_in) begin
      symbol_tick_out <= 1'b0;
    end else begin
      symbol_tick_out <= sym_wrap;
    end
  end

  // ========================================================================
  // correlation buffer
  logic [CORR_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic in_frame_q;

  // symbols outside a frame are dropped, never buffered
  pmbl_fifo #(
    .WIDTH(CORR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_data_in(corr_data_in),
    .wr_valid_in(corr_valid_in && in_frame_q),
    .wr_ready_out(corr_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready)
  );

  // ========================================================================
  // link quality accumulation
  localparam int ACC_W = CORR_W + 8;
  logic [ACC_W-1:0] acc_q;
  logic [7:0] nsym_q;
  logic end_pend_q;
  logic [7:0] lqi_d;
  logic [ACC_W-1:0] mean;

  // drain stalls once enough symbols are gathered, so the fifo may fill
  assign fifo_ready = in_frame_q && (nsym_q < 8'(LQI_SYMS));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      in_frame_q <= 1'b0;
    end else if (sync_header_in) begin
      in_frame_q <= 1'b1;
    end else if (frame_end_in) begin
      in_frame_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || sync_header_in) begin
      acc_q <= '0;
      nsym_q <= 8'h00;
    end else if (fifo_valid && fifo_ready) begin
      acc_q <= acc_q + ACC_W'(fifo_data);
      nsym_q <= nsym_q + 8'h01;
    end
  end

  // mean correlation rescaled to full 8-bit range
  always_comb begin
    mean = (nsym_q == 8'h00) ? '0 : acc_q / ACC_W'(nsym_q);
    if (CORR_W >= 8) begin
      lqi_d = 8'(mean >> (CORR_W - 8));
    end else begin
      lqi_d = 8'(mean << (8 - CORR_W)) | 8'(mean >> (2 * CORR_W - 8));
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      end_pend_q <= 1'b0;
    end else begin
      end_pend_q <= frame_end_in && in_frame_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lqi_out <= 8'h00;
    end else if (end_pend_q) begin
      lqi_out <= lqi_d;
    end
  end

  // publish wins over a sync header in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lqi_valid_out <= 1'b0;
    end else if (end_pend_q) begin
      lqi_valid_out <= 1'b1;
    end else if (sync_header_in) begin
      lqi_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      frame_done_interrupt_out <= 1'b0;
    end else begin
      frame_done_interrupt_out <= end_pend_q;
    end
  end
endmodule

// ### pmbl_regs.svh
// register offsets, field positions, reset values and timing counts for the phy mode block
`ifndef PMBL_REGS_SVH
`define PMBL_REGS_SVH
`define PMBL_CTRL_ADDR 8'h0c
`define PMBL_CTRL_RESET 8'h24
`define PMBL_RATE_LSB 0
`define PMBL_RATE_MSB 1
`define PMBL_SUBMODE_BIT 2
`define PMBL_MOD_BIT 3
`define PMBL_ALT_BIT 4
`define PMBL_SCRAM_BIT 5
`define PMBL_CLK_MHZ 100
`define PMBL_SYM_US_BPSK20 50
`define PMBL_SYM_US_BPSK40 25
`define PMBL_SYM_US_OQ400 40
`define PMBL_SYM_US_OQ1000 16
`define PMBL_SYM_CYC(us) ((us) * `PMBL_CLK_MHZ)
`define PMBL_LQI_SYMS 8
`endif

// ### pmbl_pkg.sv
// types shared by the phy mode block
package pmbl_pkg;
  typedef enum logic [1:0] {
    PMBL_SHAPE_RC10,
    PMBL_SHAPE_SIN_RC02,
    PMBL_SHAPE_RC02,
    PMBL_SHAPE_SIN
  } pmbl_shape_base_e;
  typedef enum logic [2:0] {
    PMBL_PS_RC10,
    PMBL_PS_SIN_RC02,
    PMBL_PS_RC02,
    PMBL_PS_SIN,
    PMBL_PS_RC08
  } pmbl_shape_e;
  typedef enum logic [1:0] {
    PMBL_SPREAD_STD,
    PMBL_SPREAD_HALF,
    PMBL_SPREAD_QUARTER
  } pmbl_spread_e;
endpackage

// ### pmbl_fifo.sv
// small synchronous fifo for correlation results
`timescale 1ns/1ps
module pmbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  logic [WIDTH-1:0] out_q;
  logic out_valid_q;
  logic load;

  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign push = wr_valid_in && wr_ready_out;
  assign load = (count_q != '0) && (!out_valid_q || rd_ready_in);
  assign pop = load;
  assign rd_data_out = out_q;
  assign rd_valid_out = out_valid_q;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else if (load) begin
      out_q <= mem_q[rd_ptr_q];
      out_valid_q <= 1'b1;
    end else if (rd_ready_in) begin
      out_valid_q <= 1'b0;
    end
  end
endmodule

// ### pmbl_phy_mode_properties.sv
// concurrent checks on the phy mode block ports
`timescale 1ns/1ps
module pmbl_phy_mode_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic radio_idle_state_in,
  input wire logic sync_header_in,
  input wire logic frame_end_in,
  input wire logic lqi_valid_out,
  input wire logic frame_done_interrupt_out,
  input wire logic modulation_select_out,
  input wire logic [9:0] chip_rate_kchip_out,
  input wire logic [9:0] payload_rate_kbps_out,
  input wire logic [1:0] spread_code_out,
  input wire logic [2:0] pulse_shape_out,
  input wire logic [15:0] symbol_cycles_out,
  input wire logic symbol_tick_out
);
  logic [1:0] up_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // decoded outputs settle one edge after release
  always_ff @(posedge clk_in) begin
    up_q <= reset_in ? 2'h0 : {up_q[0], 1'b1};
  end
  a_bpsk_mode_ok: assert property (up_q[1] && !modulation_select_out |->
    chip_rate_kchip_out inside {10'h12c, 10'h258} && pulse_shape_out == 3'h0)
    else $error("bpsk mode wrong");
  a_oqpsk_chip_rate: assert property (up_q[1] && modulation_select_out |->
    chip_rate_kchip_out inside {10'h190, 10'h3e8})
    else $error("oqpsk chip rate wrong");
  a_shape_slow_chip: assert property (chip_rate_kchip_out == 10'h190 |->
    pulse_shape_out inside {3'h1, 3'h2})
    else $error("shaping at 400 wrong");
  a_shape_fast_chip: assert property (chip_rate_kchip_out == 10'h3e8 |->
    pulse_shape_out inside {3'h3, 3'h4})
    else $error("shaping at 1000 wrong");
  a_oqpsk_rate_ok: assert property (up_q[1] && modulation_select_out |->
    payload_rate_kbps_out == ((chip_rate_kchip_out == 10'h190 ? 10'h064 : 10'h0fa) << spread_code_out))
    else $error("payload rate wrong");
  a_symbol_period_ok: assert property (up_q[1] |-> symbol_cycles_out ==
    (chip_rate_kchip_out == 10'h12c ? 16'h1388 : chip_rate_kchip_out == 10'h258 ? 16'h09c4 :
    chip_rate_kchip_out == 10'h190 ? 16'h0fa0 : 16'h0640))
    else $error("symbol period wrong");
  a_mode_held_busy: assert property (!radio_idle_state_in [*3] |->
    $stable(chip_rate_kchip_out) && $stable(pulse_shape_out) && $stable(payload_rate_kbps_out))
    else $error("mode changed outside idle");
  a_lqi_at_end: assert property (frame_end_in |-> ##2 frame_done_interrupt_out && lqi_valid_out)
    else $error("link quality not published");
  a_irq_one_cycle: assert property (frame_done_interrupt_out |=> !frame_done_interrupt_out)
    else $error("interrupt too long");
  a_sync_clears_lqi: assert property (sync_header_in |=> !lqi_valid_out)
    else $error("valid not cleared");
  a_tick_one_cycle: assert property (symbol_tick_out |=> !symbol_tick_out)
    else $error("symbol tick too long");
  a_tick_idle_quiet: assert property (radio_idle_state_in |=> !symbol_tick_out)
    else $error("symbol tick while idle");
endmodule

// ### pmbl_peer.sv
// peer radio model: sync pulse, correlation results, frame end
`timescale 1ns/1ps
module pmbl_peer (
  input wire logic clk_in,
  input wire logic corr_ready_in,
  output logic sync_out,
  output logic [7:0] data_out,
  output logic valid_out,
  output logic end_out
);
  logic [7:0] sym [0:31];
  int refused = 0;
  initial begin
    sync_out = 0;
    data_out = 8'ha5;
    valid_out = 0;
    end_out = 0;
  end
  task automatic send_frame(input int n);
    int k;
    @(posedge clk_in);
    sync_out <= 1;
    @(posedge clk_in);
    sync_out <= 0;
    for (int i = 0; i < n; i++) begin
      valid_out <= 1;
      data_out <= sym[i];
      k = 0;
      do begin
        @(posedge clk_in);
        k++;
      end while (!corr_ready_in && k < 20);
      if (!corr_ready_in) refused++;
      // odd symbols and the last one pause a cycle, other even ones run back to back
      if (i % 2 == 1 || i == n - 1) begin
        valid_out <= 0;
        data_out <= ~sym[i];
        @(posedge clk_in);
      end
    end
    end_out <= 1;
    @(posedge clk_in);
    end_out <= 0;
  endtask
endmodule

// ### pmbl_phy_mode_bench.sv
// self-checking bench for the phy mode block
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, e, g)
module pmbl_phy_mode_bench;
  logic clk_in = 0;
  logic reset_in = 1;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, corr_data_in, lqi_out;
  logic reg_write_in = 0, reg_read_in = 0, radio_idle_state_in = 1, short_ack_enable_in = 0;
  logic sync_header_in, corr_valid_in, corr_ready_out, frame_end_in, lqi_valid_out;
  logic frame_done_interrupt_out, modulation_select_out, snap = 0, rd_pend = 0;
  logic symbol_tick_out, scrambler_enable_out;
  logic [47:0] exp_m, got_m;
  logic [9:0] chip_rate_kchip_out, payload_rate_kbps_out;
  logic [1:0] spread_code_out, ack_symbols_out;
  logic [2:0] pulse_shape_out;
  logic [15:0] symbol_cycles_out;
  logic [7:0] rd_q[$];
  logic [8:0] lqi_q[$];
  logic [47:0] mode_q[$];
  logic [31:0] r;
  logic [7:0] v;
  int n_errors = 0, check_count = 0, seed = 91, t = 0;
  pmbl_phy_mode i_pmbl_phy_mode (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .radio_idle_state_in, .short_ack_enable_in, .sync_header_in,
    .corr_data_in, .corr_valid_in, .corr_ready_out, .frame_end_in, .lqi_out, .lqi_valid_out,
    .frame_done_interrupt_out, .modulation_select_out, .chip_rate_kchip_out,
    .payload_rate_kbps_out, .spread_code_out, .pulse_shape_out, .scrambler_enable_out,
    .symbol_cycles_out, .symbol_tick_out, .ack_symbols_out);
  pmbl_peer i_pmbl_peer (.clk_in, .corr_ready_in(corr_ready_out), .sync_out(sync_header_in),
    .data_out(corr_data_in), .valid_out(corr_valid_in), .end_out(frame_end_in));
  assign got_m = {chip_rate_kchip_out, payload_rate_kbps_out, spread_code_out, pulse_shape_out,
    symbol_cycles_out, ack_symbols_out, 4'h0, scrambler_enable_out};
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  function automatic void chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endfunction
  // expected mode outputs packed as in the monitor
  function automatic logic [47:0] mexp(input logic [7:0] c, input logic s);
    logic [1:0] sp;
    logic [9:0] rt;
    sp = c[3] ? (c[1:0] == 2'h0 ? 2'h0 : (c[1] ? 2'h2 : 2'h1)) : 2'h0;
    rt = c[3] ? ((c[2] ? 10'h0fa : 10'h064) << sp) : (c[2] ? 10'h028 : 10'h014);
    return {c[3] ? (c[2] ? 10'h3e8 : 10'h190) : (c[2] ? 10'h258 : 10'h12c), rt, sp,
      c[3] ? 3'h1 + {1'b0, c[2], c[4]} : 3'h0,
      c[3] ? (c[2] ? 16'h0640 : 16'h0fa0) : (c[2] ? 16'h09c4 : 16'h1388),
      (s && sp != 2'h0) ? (c[2] ? 2'h3 : 2'h2) : 2'h0, 4'h0, c[3] & c[5] & c[1]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_write_in <= w;
    reg_read_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_write_in <= 0;
    reg_read_in <= 0;
  endtask
  task automatic look();
    @(posedge clk_in);
    snap <= 1;
    @(posedge clk_in);
    snap <= 0;
  endtask
  task automatic frame(input int n);
    int s = 0;
    for (int i = 0; i < n; i++) begin
      i_pmbl_peer.sym[i] = 8'($random(seed));
      if (i < 8) s += i_pmbl_peer.sym[i];
    end
    lqi_q.push_back({1'b1, n == 0 ? 8'h00 : 8'(s / (n < 8 ? n : 8))});
    i_pmbl_peer.send_frame(n);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // monitor
  always @(posedge clk_in) begin
    rd_pend <= reg_read_in;
    if (rd_pend) `CHK("ctrl read", rd_q.pop_front(), reg_rdata_out);
    if (snap) begin
      exp_m = mode_q.pop_front();
      `CHK("mode rates", exp_m[47:28], got_m[47:28]);
      `CHK("mode timing", exp_m[27:0], got_m[27:0]);
    end
    if (frame_done_interrupt_out) begin
      `CHK("lqi", lqi_q.pop_front(), {lqi_valid_out, lqi_out});
    end
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  // ====
  // sequence
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 0;
    rd_q.push_back(8'h24);
    bus(0, 8'h0c, 8'h00);
    rd_q.push_back(8'h00);
    bus(0, 8'h0d, 8'h00);
    mode_q.push_back(mexp(8'h24, 1'b0));
    look();
    $display("reset test done");
    for (int c = 0; c < 32; c++) begin
      r = $random(seed);
      v = {r[7:5], c[4:0]};
      short_ack_enable_in <= r[8];
      bus(1, 8'h0c, v);
      repeat (3) @(posedge clk_in);
      mode_q.push_back(mexp(v, r[8]));
      look();
      rd_q.push_back(v & 8'h3f);
      bus(0, 8'h0c, 8'h00);
    end
    $display("mode table test done");
    radio_idle_state_in <= 0;
    bus(1, 8'h0c, 8'h18);
    repeat (3) @(posedge clk_in);
    mode_q.push_back(mexp(v, r[8]));
    look();
    radio_idle_state_in <= 1;
    repeat (3) @(posedge clk_in);
    mode_q.push_back(mexp(8'h18, r[8]));
    look();
    $display("idle hold test done");
    radio_idle_state_in <= 0;
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while (!symbol_tick_out && t < 5000);
    `CHK("first tick", 1, symbol_tick_out);
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while (!symbol_tick_out && t < 5000);
    `CHK("symbol period", 4000, t);
    radio_idle_state_in <= 1;
    $display("symbol tick test done");
    frame(0);
    frame(3);
    frame(8);
    frame(18);
    `CHK("refused symbols", 1, i_pmbl_peer.refused);
    `CHK("lqi pending", 0, lqi_q.size());
    $display("link quality test done");
    end_of_test();
  end
endmodule
bind pmbl_phy_mode pmbl_phy_mode_properties i_props (.clk_in, .reset_in, .radio_idle_state_in,
  .sync_header_in, .frame_end_in, .lqi_valid_out, .frame_done_interrupt_out,
  .modulation_select_out, .chip_rate_kchip_out, .payload_rate_kbps_out, .spread_code_out,
  .pulse_shape_out, .symbol_cycles_out, .symbol_tick_out);
